// file: verilog/cedp_pkg.sv
// shared constants and carriers for the exception detection and priority unit
package cedp_pkg;
  // vectors
  localparam logic [7:0] VEC_DIVIDE = 8'h00;
  localparam logic [7:0] VEC_NMI    = 8'h02;
  localparam logic [7:0] VEC_INVOP  = 8'h06;
  localparam logic [7:0] VEC_DOUBLE = 8'h08;
  localparam logic [7:0] VEC_GPROT  = 8'h0d;
  localparam logic [7:0] VEC_XLAT   = 8'h0e;
  localparam logic [7:0] VEC_ALIGN  = 8'h11;
  localparam logic [7:0] VEC_MCHK   = 8'h12;

  // register byte offsets
  localparam logic [7:0] OFS_EXT_CTRL  = 8'h00;
  localparam logic [7:0] OFS_IDT_LIMIT = 8'h04;
  localparam logic [7:0] OFS_STATUS    = 8'h08;
  localparam logic [7:0] OFS_DBG_STAT  = 8'h0c;
  localparam logic [7:0] OFS_DBG_CTRL  = 8'h10;
  localparam logic [7:0] OFS_PDBASE    = 8'h14;
  localparam logic [7:0] OFS_LAST_EIP  = 8'h18;

  // extension control fields
  localparam int CTL_DBG_EXT  = 0;
  localparam int CTL_MCE      = 1;
  localparam int CTL_VME      = 2;
  localparam int CTL_ALIGN    = 3;
  localparam int CTL_PROT     = 4;
  localparam logic [31:0] CTL_RSVD_MASK = 32'hffff_ffe0;
  localparam logic [31:0] CTL_RESET     = 32'h0000_0000;

  // status fields
  localparam int ST_SHUTDOWN = 8;
  localparam int ST_NMI_BLK  = 9;

  // debug slot numbers
  localparam logic [2:0] DSLOT_FOUR   = 3'h4;
  localparam logic [2:0] DSLOT_FIVE   = 3'h5;
  localparam logic [2:0] DSLOT_STATUS = 3'h6;
  localparam logic [2:0] DSLOT_CTRL   = 3'h7;

  // limits and sizes
  localparam logic [4:0]  MAX_INSN_LEN  = 5'h0f;
  localparam logic [15:0] IDT_RESET     = 16'h03ff;
  localparam logic [31:0] DBG_STAT_RST  = 32'h0000_0000;
  localparam logic [31:0] DBG_CTRL_RST  = 32'h0000_0000;

  typedef enum logic [1:0] {DIV_BYTE, DIV_WORD, DIV_DWORD} cedp_dsize_t;

  // one instruction worth of decode and execution information
  typedef struct packed {
    logic        valid;
    logic [31:0] eip;
    logic [4:0]  len;
    logic        lock_bad;
    logic        test_reg;
    logic        dbg_acc;
    logic        dbg_wr;
    logic [2:0]  dbg_num;
    logic [31:0] wdata;
    logic        sreg_wr;
    logic        cs_write;
    logic        unaligned;
    logic        div_op;
    logic        div_signed;
    logic        div_zero;
    cedp_dsize_t div_size;
    logic [32:0] div_quot;
    logic        swint;
    logic [7:0]  swint_vec;
    logic        v86;
    logic        redir_bit;
  } cedp_insn_t;

  typedef struct packed {
    logic        pte_rsvd;
    logic        pde_rsvd;
    logic        pdp_rsvd;
  } cedp_xlat_t;

  typedef struct packed {
    logic [7:0]  vector;
    logic [31:0] eip;
  } cedp_evt_t;
endpackage

// file: verilog/cedp_unit.sv
// exception detection, prioritisation and delivery unit
//
// Chosen here: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
module cedp_unit (
  // clock and reset
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  // wishbone slave
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [7:0]          wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  // pipeline and external sources
  input  wire cedp_pkg::cedp_insn_t insn_i,
  input  wire cedp_pkg::cedp_xlat_t xlat_i,
  input  wire logic                trap_i,
  input  wire logic [7:0]          trap_vec_i,
  input  wire logic                fetch_fault_i,
  input  wire logic [7:0]          fetch_vec_i,
  input  wire logic                nmi_i,
  input  wire logic                intr_i,
  input  wire logic [7:0]          intr_vec_i,
  input  wire logic                mc_error_i,
  input  wire logic                interrupt_return_done_i,
  input  wire logic                ts_i,
  input  wire logic                ts_16bit_i,
  input  wire logic [31:0]         ts_pdbase_i,
  // results
  output logic                     evt_valid_o,
  output cedp_pkg::cedp_evt_t      evt_o,
  output logic                     redirect_o,
  output logic [7:0]               redirect_vec_o,
  output logic                     shutdown_o,
  output logic [31:0]              dbg_rdata_o,
  output logic [31:0]              quot_o,
  output logic [31:0]              page_dir_base_o
);
  logic [31:0]         ctl_q;
  logic [15:0]         idt_lim_q;
  logic [31:0]         dstat_q;
  logic [31:0]         dctl_q;
  logic [31:0]         pdb_q;
  logic [31:0]         last_eip_q;
  logic                nmi_blk_q;
  logic                shut_q;
  logic                ack_q;
  logic [31:0]         rdat_q;
  logic                evt_q;
  cedp_pkg::cedp_evt_t evt_data_q;
  logic                redir_q;
  logic [7:0]          redir_vec_q;
  logic [31:0]         drd_q;
  logic [31:0]         quot_q;

  logic                has_d;
  logic [7:0]          vec_d;
  logic                nmi_take;
  logic                slot_alias;
  logic [2:0]          dslot;
  logic                dbg_fault;
  logic                sreg_bad;
  logic                div_ovf;
  logic                sw_redirect;
  logic                beyond_vec;
  logic                beyond_df;
  logic                wb_wr;

  // true when the last byte of a gate lies past the table limit
  function automatic logic beyond(input logic [7:0] v, input logic [15:0] lim, input logic pm);
    logic [18:0] last;
    last = pm ? {8'h00, v, 3'h7} : {9'h000, v, 2'h3};
    return last > {3'h0, lim};
  endfunction

  // signed quotient range check for the operand size
  function automatic logic quot_ovf(input logic [32:0] q, input cedp_pkg::cedp_dsize_t s);
    logic ovf;
    case (s)
      cedp_pkg::DIV_BYTE:  ovf = ($signed(q) < -33'sd128) || ($signed(q) > 33'sd127);
      cedp_pkg::DIV_WORD:  ovf = ($signed(q) < -33'sd32768) || ($signed(q) > 33'sd32767);
      default:             ovf = (q[32] != q[31]);
    endcase
    return ovf;
  endfunction

  assign wb_wr = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q && (wb_sel_i == 4'hf);

  // debug slot mapping
  assign slot_alias = (insn_i.dbg_num == cedp_pkg::DSLOT_FOUR) ||
                      (insn_i.dbg_num == cedp_pkg::DSLOT_FIVE);
  assign dbg_fault  = insn_i.dbg_acc && slot_alias && ctl_q[cedp_pkg::CTL_DBG_EXT];
  assign dslot      = (slot_alias && !ctl_q[cedp_pkg::CTL_DBG_EXT]) ?
                      {1'b1, 1'b1, insn_i.dbg_num[0]} : insn_i.dbg_num;

  assign sreg_bad    = insn_i.sreg_wr && ((insn_i.wdata & cedp_pkg::CTL_RSVD_MASK) != 32'h0);
  assign div_ovf     = insn_i.div_op && (insn_i.div_zero ||
                       (insn_i.div_signed ? quot_ovf(insn_i.div_quot, insn_i.div_size)
                                          : (insn_i.div_quot[32:31] != 2'b00)));
  assign sw_redirect = insn_i.swint && insn_i.v86 && ctl_q[cedp_pkg::CTL_VME] &&
                       !insn_i.redir_bit;
  assign nmi_take    = nmi_i && !nmi_blk_q;

  // category order first, fixed order inside a category
  always_comb begin
    has_d = 1'b1;
    vec_d = 8'h00;
    if (trap_i) begin
      vec_d = trap_vec_i;
    end else if (mc_error_i && ctl_q[cedp_pkg::CTL_MCE]) begin
      vec_d = cedp_pkg::VEC_MCHK;
    end else if (nmi_take) begin
      vec_d = cedp_pkg::VEC_NMI;
    end else if (intr_i) begin
      vec_d = intr_vec_i;
    end else if (fetch_fault_i) begin
      vec_d = fetch_vec_i;
    end else if (insn_i.valid && insn_i.len > cedp_pkg::MAX_INSN_LEN) begin
      vec_d = cedp_pkg::VEC_GPROT;
    end else if (insn_i.valid && (insn_i.lock_bad || insn_i.test_reg || dbg_fault)) begin
      vec_d = cedp_pkg::VEC_INVOP;
    end else if (insn_i.valid && sreg_bad) begin
      vec_d = cedp_pkg::VEC_GPROT;
    end else if (insn_i.valid && insn_i.cs_write && ctl_q[cedp_pkg::CTL_PROT]) begin
      vec_d = cedp_pkg::VEC_GPROT;
    end else if (insn_i.valid && (xlat_i.pte_rsvd || xlat_i.pde_rsvd || xlat_i.pdp_rsvd)) begin
      vec_d = cedp_pkg::VEC_XLAT;
    end else if (insn_i.valid && insn_i.unaligned && ctl_q[cedp_pkg::CTL_ALIGN]) begin
      vec_d = cedp_pkg::VEC_ALIGN;
    end else if (insn_i.valid && div_ovf) begin
      vec_d = cedp_pkg::VEC_DIVIDE;
    end else if (insn_i.valid && insn_i.swint && !sw_redirect) begin
      vec_d = insn_i.swint_vec;
    end else begin
      has_d = 1'b0;
    end
  end

  assign beyond_vec = beyond(vec_d, idt_lim_q, ctl_q[cedp_pkg::CTL_PROT]);
  assign beyond_df  = beyond(cedp_pkg::VEC_DOUBLE, idt_lim_q, ctl_q[cedp_pkg::CTL_PROT]);

  // event delivery and escalation
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      evt_q      <= 1'b0;
      evt_data_q <= '0;
      shut_q     <= 1'b0;
      last_eip_q <= 32'h0;
    end else begin
      evt_q <= 1'b0;
      if (has_d && !shut_q) begin
        if (beyond_vec && beyond_df) begin
          shut_q <= 1'b1;
        end else begin
          evt_q             <= 1'b1;
          evt_data_q.vector <= beyond_vec ? cedp_pkg::VEC_DOUBLE : vec_d;
          evt_data_q.eip    <= insn_i.eip;
          last_eip_q        <= insn_i.eip;
        end
      end
    end
  end

  // nmi masking, set wins over the clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nmi_blk_q <= 1'b0;
    end else if (nmi_take && !trap_i && !(mc_error_i && ctl_q[cedp_pkg::CTL_MCE]) && !shut_q) begin
      nmi_blk_q <= 1'b1;
    end else if (interrupt_return_done_i) begin
      nmi_blk_q <= 1'b0;
    end
  end

  // software interrupt redirection to the virtual mode program
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      redir_q     <= 1'b0;
      redir_vec_q <= 8'h00;
    end else begin
      redir_q <= insn_i.valid && sw_redirect && !has_d && !shut_q;
      if (insn_i.valid && sw_redirect) begin
        redir_vec_q <= insn_i.swint_vec;
      end
    end
  end

  // extension control register, written by software or the pipeline
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_q <= cedp_pkg::CTL_RESET;
    end else if (insn_i.valid && insn_i.sreg_wr && !has_d) begin
      ctl_q <= insn_i.wdata;
    end else if (wb_wr && wb_adr_i == cedp_pkg::OFS_EXT_CTRL &&
                 (wb_dat_i & cedp_pkg::CTL_RSVD_MASK) == 32'h0) begin
      ctl_q <= wb_dat_i;
    end
  end

  // debug status and control, reached directly or by alias
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dstat_q <= cedp_pkg::DBG_STAT_RST;
      dctl_q  <= cedp_pkg::DBG_CTRL_RST;
      drd_q   <= 32'h0;
    end else begin
      if (insn_i.valid && insn_i.dbg_acc && !dbg_fault && !has_d) begin
        if (insn_i.dbg_wr && dslot == cedp_pkg::DSLOT_STATUS) begin
          dstat_q <= insn_i.wdata;
        end
        if (insn_i.dbg_wr && dslot == cedp_pkg::DSLOT_CTRL) begin
          dctl_q <= insn_i.wdata;
        end
        if (!insn_i.dbg_wr) begin
          drd_q <= (dslot == cedp_pkg::DSLOT_STATUS) ? dstat_q :
                   (dslot == cedp_pkg::DSLOT_CTRL)   ? dctl_q  : 32'h0;
        end
      end else if (wb_wr && wb_adr_i == cedp_pkg::OFS_DBG_STAT) begin
        dstat_q <= wb_dat_i;
      end else if (wb_wr && wb_adr_i == cedp_pkg::OFS_DBG_CTRL) begin
        dctl_q <= wb_dat_i;
      end
    end
  end

  // divide result and directory base
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      quot_q <= 32'h0;
      pdb_q  <= 32'h0;
    end else begin
      if (insn_i.valid && insn_i.div_op && !div_ovf) begin
        quot_q <= insn_i.div_quot[31:0];
      end
      if (ts_i && !ts_16bit_i) begin
        pdb_q <= ts_pdbase_i;
      end
    end
  end

  // table limit register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idt_lim_q <= cedp_pkg::IDT_RESET;
    end else if (wb_wr && wb_adr_i == cedp_pkg::OFS_IDT_LIMIT) begin
      idt_lim_q <= wb_dat_i[15:0];
    end
  end

  // wishbone answer, one wait state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0;
    end else begin
      ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
      case (wb_adr_i)
        cedp_pkg::OFS_EXT_CTRL:  rdat_q <= ctl_q;
        cedp_pkg::OFS_IDT_LIMIT: rdat_q <= {16'h0000, idt_lim_q};
        cedp_pkg::OFS_STATUS:    rdat_q <= {22'h0, nmi_blk_q, shut_q, evt_data_q.vector};
        cedp_pkg::OFS_DBG_STAT:  rdat_q <= dstat_q;
        cedp_pkg::OFS_DBG_CTRL:  rdat_q <= dctl_q;
        cedp_pkg::OFS_PDBASE:    rdat_q <= pdb_q;
        cedp_pkg::OFS_LAST_EIP:  rdat_q <= last_eip_q;
        default:                 rdat_q <= 32'h0;
      endcase
    end
  end

  assign wb_ack_o        = ack_q;
  assign wb_dat_o        = rdat_q;
  assign evt_valid_o     = evt_q;
  assign evt_o           = evt_data_q;
  assign redirect_o      = redir_q;
  assign redirect_vec_o  = redir_vec_q;
  assign shutdown_o      = shut_q;
  assign dbg_rdata_o     = drd_q;
  assign quot_o          = quot_q;
  assign page_dir_base_o = pdb_q;

  a_alias_ud: assert property (@(posedge clk_i) disable iff (rst_i)
    insn_i.valid && insn_i.dbg_acc && slot_alias && ctl_q[cedp_pkg::CTL_DBG_EXT] && !trap_i &&
    !nmi_i && !intr_i && !mc_error_i && !fetch_fault_i && insn_i.len <= cedp_pkg::MAX_INSN_LEN &&
    !beyond_vec && !shut_q
    |=> evt_valid_o && evt_o.vector == 8'h06)
    else $error("reserved debug slot did not fault");

  a_test_reg: assert property (@(posedge clk_i) disable iff (rst_i)
    insn_i.valid && insn_i.test_reg && !trap_i && !nmi_take && !intr_i && !fetch_fault_i &&
    !(mc_error_i && ctl_q[cedp_pkg::CTL_MCE]) && insn_i.len <= cedp_pkg::MAX_INSN_LEN &&
    !beyond_vec && !shut_q
    |=> evt_valid_o && evt_o.vector == cedp_pkg::VEC_INVOP)
    else $error("test register move did not fault");

  a_mc_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    mc_error_i && !ctl_q[cedp_pkg::CTL_MCE] && !trap_i && !intr_i && !fetch_fault_i &&
    !(insn_i.valid && insn_i.swint)
    |=> !(evt_valid_o && evt_o.vector == cedp_pkg::VEC_MCHK))
    else $error("machine check delivered while disabled");

  a_div_eip: assert property (@(posedge clk_i) disable iff (rst_i)
    evt_valid_o && evt_o.vector == 8'h00 && !$past(trap_i) && !$past(intr_i)
    |-> evt_o.eip == $past(insn_i.eip))
    else $error("divide fault eip not the divide");

  a_min_quot: assert property (@(posedge clk_i) disable iff (rst_i)
    insn_i.valid && insn_i.div_op && insn_i.div_signed && !insn_i.div_zero &&
    insn_i.div_size == cedp_pkg::DIV_BYTE && insn_i.div_quot == 33'h1_ffff_ff80
    |=> quot_o == 32'hffff_ff80)
    else $error("most negative quotient not returned");

  a_nmi_block: assert property (@(posedge clk_i) disable iff (rst_i)
    nmi_blk_q && !interrupt_return_done_i |=> nmi_blk_q ##0 !(evt_valid_o && evt_o.vector == 8'h02 &&
    $past(!trap_i && !intr_i && !mc_error_i && !fetch_fault_i && !insn_i.valid)))
    else $error("nmi not held blocked");

  a_df_escal: assert property (@(posedge clk_i) disable iff (rst_i)
    has_d && !shut_q && beyond_vec && !beyond_df
    |=> evt_valid_o && evt_o.vector == 8'h08)
    else $error("limit violation did not double fault");

  a_shutdown: assert property (@(posedge clk_i) disable iff (rst_i)
    has_d && beyond_vec && beyond_df |=> (shutdown_o && !evt_valid_o) [*2])
    else $error("shutdown not entered");

  a_pdb_keep: assert property (@(posedge clk_i) disable iff (rst_i)
    ts_i && ts_16bit_i |=> $stable(page_dir_base_o))
    else $error("directory base changed on 16-bit switch");

  a_len_gp: assert property (@(posedge clk_i) disable iff (rst_i)
    insn_i.valid && insn_i.len == 5'h10 && !trap_i && !nmi_take && !intr_i &&
    !(mc_error_i && ctl_q[1]) && !fetch_fault_i && !beyond_vec && !shut_q
    |=> evt_valid_o && evt_o.vector == 8'h0d)
    else $error("overlong instruction not faulted");
endmodule // cedp_unit

// file: verification/cedp_src_model.sv
// pipeline and interrupt source model that drives the unit's inputs
`timescale 1ns/1ps
module cedp_src_model (
  // pipeline
  output cedp_pkg::cedp_insn_t insn_o,
  output cedp_pkg::cedp_xlat_t xlat_o,
  // sources {trap, machine check, nmi, intr, fetch fault}
  output logic [4:0]           src_o,
  // {interrupt return, task switch, 16-bit task}
  output logic [2:0]           misc_o,
  output logic [31:0]          ts_pdbase_o
);
  initial begin
    insn_o = '0;
    xlat_o = '0;
    src_o = 5'h00;
    misc_o = 3'h0;
    ts_pdbase_o = 32'h0;
  end

  task automatic present(input cedp_pkg::cedp_insn_t i, input cedp_pkg::cedp_xlat_t x,
                         input logic [4:0] s, input logic [2:0] m, input logic [31:0] pd);
    insn_o <= i;
    xlat_o <= x;
    src_o <= s;
    misc_o <= m;
    ts_pdbase_o <= pd;
  endtask

  // released fields show inverted data, while valid and the source and misc lines go low, so a stale value is never trusted
  task automatic idle();
    cedp_pkg::cedp_insn_t t;
    t = ~insn_o;
    t.valid = 1'b0;
    insn_o <= t;
    xlat_o <= ~xlat_o;
    src_o <= 5'h00;
    misc_o <= 3'h0;
    ts_pdbase_o <= ~ts_pdbase_o;
  endtask
endmodule // cedp_src_model

// file: verification/testbench.sv
// self-checking bench for the exception detection and priority unit
`timescale 1ns/1ps
module testbench;
  localparam logic [7:0] TRAPV = 8'h03;
  localparam logic [7:0] INTV  = 8'h40;
  localparam logic [7:0] FETV  = 8'h0b;
  // rows: {ext ctrl, kind, event expected, vector}
  localparam logic [17:0] ROWS [18] = '{
    {5'h10, 4'h0, 1'b1, 8'h0d}, {5'h10, 4'h1, 1'b0, 8'h00}, {5'h00, 4'h2, 1'b1, 8'h06},
    {5'h00, 4'h3, 1'b1, 8'h06}, {5'h01, 4'h4, 1'b1, 8'h06}, {5'h10, 4'h5, 1'b1, 8'h0d},
    {5'h00, 4'h5, 1'b0, 8'h00}, {5'h10, 4'h6, 1'b1, 8'h0e}, {5'h10, 4'h7, 1'b1, 8'h0e},
    {5'h10, 4'h8, 1'b1, 8'h0e}, {5'h18, 4'h9, 1'b1, 8'h11}, {5'h10, 4'h9, 1'b0, 8'h00},
    {5'h10, 4'ha, 1'b1, 8'h00}, {5'h18, 4'hb, 1'b1, 8'h11}, {5'h10, 4'hc, 1'b1, 8'h0d},
    {5'h10, 4'hd, 1'b0, 8'h00}, {5'h12, 4'hd, 1'b1, 8'h12}, {5'h00, 4'h4, 1'b0, 8'h00}};

  logic                 clk_i    = 1'b0;
  logic                 rst_i    = 1'b1;
  logic                 wb_cyc_i = 1'b0;
  logic                 wb_stb_i = 1'b0;
  logic                 wb_we_i  = 1'b0;
  logic [7:0]           wb_adr_i = 8'h00;
  logic [3:0]           wb_sel_i = 4'h0;
  logic [31:0]          wb_dat_i = 32'h0;
  logic [31:0]          wb_dat_o;
  logic                 wb_ack_o;
  cedp_pkg::cedp_insn_t insn;
  cedp_pkg::cedp_xlat_t xlat;
  logic [4:0]           src;
  logic [2:0]           misc;
  logic [31:0]          pdb;
  logic                 evt_valid_o;
  cedp_pkg::cedp_evt_t  evt_o;
  logic                 redirect_o;
  logic [7:0]           redirect_vec_o;
  logic                 shutdown_o;
  logic [31:0]          quot_o;
  logic [31:0]          dbg_rdata_o;
  logic [31:0]          page_dir_base_o;
  int                   miscompares = 0;
  int                   cmp_count   = 0;

  cedp_src_model i_cedp_src_model (.insn_o(insn), .xlat_o(xlat), .src_o(src), .misc_o(misc),
                                   .ts_pdbase_o(pdb));

  cedp_unit i_cedp_unit (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .insn_i(insn), .xlat_i(xlat), .trap_i(src[4]), .trap_vec_i(TRAPV),
    .fetch_fault_i(src[0]), .fetch_vec_i(FETV), .nmi_i(src[2]), .intr_i(src[1]),
    .intr_vec_i(INTV), .mc_error_i(src[3]), .interrupt_return_done_i(misc[2]), .ts_i(misc[1]),
    .ts_16bit_i(misc[0]), .ts_pdbase_i(pdb), .evt_valid_o(evt_valid_o), .evt_o(evt_o),
    .redirect_o(redirect_o), .redirect_vec_o(redirect_vec_o), .shutdown_o(shutdown_o),
    .dbg_rdata_o(dbg_rdata_o), .quot_o(quot_o), .page_dir_base_o(page_dir_base_o));

  initial begin
    forever #20 clk_i = ~clk_i;
  end

  task automatic end_sim();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask

  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    if (wb_ack_o !== 1'b1) begin
      miscompares++;
      end_sim();
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check({16'h0, q}, {16'h0, e});
  endtask

  // present one cycle of stimulus and compare the event that follows it
  task automatic ev(input cedp_pkg::cedp_insn_t i, input cedp_pkg::cedp_xlat_t x,
                    input logic [4:0] s, input logic v, input logic [7:0] vec,
                    input logic [2:0] m = 3'h0, input logic [31:0] pd = 32'h0);
    @(posedge clk_i);
    i_cedp_src_model.present(i, x, s, m, pd);
    @(posedge clk_i);
    i_cedp_src_model.idle();
    @(posedge clk_i);
    check({7'h0, evt_valid_o, v ? evt_o : 40'h0}, {7'h0, v, v ? {vec, i.eip} : 40'h0});
  endtask

  function automatic cedp_pkg::cedp_insn_t mk(input logic [3:0] k);
    cedp_pkg::cedp_insn_t t;
    t = '0;
    t.valid = 1'b1;
    t.eip = {28'h0000100, k};
    t.len = (k == 4'h0 || k == 4'hc) ? 5'h10 : 5'h0f;
    t.lock_bad = (k == 4'h2 || k == 4'hc);
    t.test_reg = (k == 4'h3);
    t.dbg_acc = (k == 4'h4);
    t.dbg_num = cedp_pkg::DSLOT_FOUR;
    t.cs_write = (k == 4'h5);
    t.unaligned = (k == 4'h9 || k == 4'hb);
    t.div_op = (k == 4'ha || k == 4'hb);
    t.div_zero = t.div_op;
    return t;
  endfunction

  function automatic cedp_pkg::cedp_xlat_t mkx(input logic [3:0] k);
    return {k == 4'h6, k == 4'h7, k == 4'h8};
  endfunction

  initial begin
    cedp_pkg::cedp_insn_t t;
    logic [3:0]           k;
    do_reset();
    rd(cedp_pkg::OFS_EXT_CTRL, cedp_pkg::CTL_RESET);
    rd(cedp_pkg::OFS_IDT_LIMIT, {16'h0, cedp_pkg::IDT_RESET});
    rd(cedp_pkg::OFS_STATUS, 32'h0);
    rd(8'h1c, 32'h0);
    wr(cedp_pkg::OFS_EXT_CTRL, 32'h0000_0021);
    rd(cedp_pkg::OFS_EXT_CTRL, 32'h0);
    for (int r = 0; r < 18; r++) begin
      k = ROWS[r][12:9];
      wr(cedp_pkg::OFS_EXT_CTRL, {27'h0, ROWS[r][17:13]});
      ev(mk(k), mkx(k), {1'b0, k == 4'hd, 3'h0}, ROWS[r][8], ROWS[r][7:0]);
    end
    // reserved bit written from the pipeline
    wr(cedp_pkg::OFS_EXT_CTRL, 32'h10);
    t = mk(4'hf);
    t.sreg_wr = 1'b1;
    t.wdata = 32'h0000_0110;
    ev(t, '0, 5'h00, 1'b1, cedp_pkg::VEC_GPROT);
    rd(cedp_pkg::OFS_EXT_CTRL, 32'h10);
    // aliased debug slots
    wr(cedp_pkg::OFS_EXT_CTRL, 32'h0);
    t = mk(4'hf);
    t.dbg_acc = 1'b1;
    t.dbg_wr = 1'b1;
    t.dbg_num = cedp_pkg::DSLOT_FOUR;
    t.wdata = 32'h0000_000f;
    ev(t, '0, 5'h00, 1'b0, 8'h00);
    t.dbg_num = cedp_pkg::DSLOT_FIVE;
    t.wdata = 32'h0000_0003;
    ev(t, '0, 5'h00, 1'b0, 8'h00);
    rd(cedp_pkg::OFS_DBG_STAT, 32'h0000_000f);
    rd(cedp_pkg::OFS_DBG_CTRL, 32'h0000_0003);
    t.dbg_wr = 1'b0;
    t.dbg_num = cedp_pkg::DSLOT_FOUR;
    ev(t, '0, 5'h00, 1'b0, 8'h00);
    check({16'h0, dbg_rdata_o}, 48'hf);
    // most negative quotients, then a byte quotient of +128 that faults
    t = mk(4'hf);
    t.div_op = 1'b1;
    t.div_signed = 1'b1;
    t.div_quot = 33'h1_ffff_ff80;
    ev(t, '0, 5'h00, 1'b0, 8'h00);
    check({40'h0, quot_o[7:0]}, 48'h80);
    t.div_size = cedp_pkg::DIV_WORD;
    t.div_quot = 33'h1_ffff_8000;
    ev(t, '0, 5'h00, 1'b0, 8'h00);
    check({32'h0, quot_o[15:0]}, 48'h8000);
    t.div_size = cedp_pkg::DIV_BYTE;
    t.div_quot = 33'h0_0000_0080;
    ev(t, '0, 5'h00, 1'b1, cedp_pkg::VEC_DIVIDE);
    // category order
    wr(cedp_pkg::OFS_EXT_CTRL, 32'h12);
    ev(mk(4'h2), '0, 5'h1f, 1'b1, TRAPV);
    ev(mk(4'h2), '0, 5'h0f, 1'b1, cedp_pkg::VEC_MCHK);
    ev(mk(4'h2), '0, 5'h03, 1'b1, INTV);
    ev(mk(4'h2), '0, 5'h01, 1'b1, FETV);
    ev(mk(4'h2), '0, 5'h00, 1'b1, cedp_pkg::VEC_INVOP);
    // nmi masking
    ev(mk(4'hf), '0, 5'h04, 1'b1, cedp_pkg::VEC_NMI);
    ev(mk(4'hf), '0, 5'h04, 1'b0, 8'h00);
    rd(cedp_pkg::OFS_STATUS, 32'h0000_0202);
    ev(mk(4'hf), '0, 5'h00, 1'b0, 8'h00, 3'h4);
    ev(mk(4'hf), '0, 5'h04, 1'b1, cedp_pkg::VEC_NMI);
    // task switches
    ev(mk(4'hf), '0, 5'h00, 1'b0, 8'h00, 3'h2, 32'h0012_3000);
    check({16'h0, page_dir_base_o}, 48'h12_3000);
    ev(mk(4'hf), '0, 5'h00, 1'b0, 8'h00, 3'h3, 32'h0045_6000);
    check({16'h0, page_dir_base_o}, 48'h12_3000);
    // software interrupt sent back through the bitmap
    wr(cedp_pkg::OFS_EXT_CTRL, 32'h04);
    t = mk(4'hf);
    t.swint = 1'b1;
    t.v86 = 1'b1;
    t.swint_vec = 8'h21;
    ev(t, '0, 5'h00, 1'b0, 8'h00);
    check({39'h0, redirect_o, redirect_vec_o}, {39'h0, 1'b1, 8'h21});
    t.redir_bit = 1'b1;
    ev(t, '0, 5'h00, 1'b1, 8'h21);
    check({47'h0, redirect_o}, 48'h0);
    // table limit escalation, then a reset in mid-run
    wr(cedp_pkg::OFS_EXT_CTRL, 32'h0);
    wr(cedp_pkg::OFS_IDT_LIMIT, 32'h27);
    ev(mk(4'h0), '0, 5'h00, 1'b1, cedp_pkg::VEC_DOUBLE);
    wr(cedp_pkg::OFS_IDT_LIMIT, 32'h10);
    ev(mk(4'h0), '0, 5'h00, 1'b0, 8'h00);
    check({47'h0, shutdown_o}, 48'h1);
    ev(mk(4'h2), '0, 5'h00, 1'b0, 8'h00);
    do_reset();
    check({47'h0, shutdown_o}, 48'h0);
    rd(cedp_pkg::OFS_EXT_CTRL, 32'h0);
    end_sim();
  end
endmodule // testbench
